// ### core/mirq_regs.sv
/*
  mirq_regs: command, interrupt status/mask, data and transmit
  configuration and transmit status registers behind an ahb-lite slave.
  assumes the mac datapath pulses the event inputs for one enabled
  clock and that the bus master issues single word transfers.
*/
// What this block does
// - reset flag sets on reset or stop, clears on start; writes ignored
// - status bit 6 sets when a remote dma finishes
// - status bit 5 sets when any tally counter msb becomes set
// - status bit 4 sets when receive ring has no room left
// - status bit 3 sets on excessive collisions or fifo underrun
// - status bit 2 sets on crc, alignment, overrun or missed packet
// - status bit 1 sets on a packet sent without error
// - status bit 0 sets on a packet received without error
// - write-only enables 6..0 match status bits, cleared at reset
// - data config bit 7 makes remote dma complete at once
// - data config bit 0 picks byte or word dma width
// - transmit config bit 7 picks half or full duplex
// - transmit config bit 6 low pads frames under 60 bytes
// - transmit config bit 5 enables retry after late collision
// - transmit config bits 2:1 pick normal, internal or phy loopback
// - transmit config bit 0 set omits the appended crc
// - transmit status bit 7 reports an out-of-window collision
// - transmit status bit 3 reports abort on excessive collisions
// - transmit status bit 2 reports at least one collision
// - transmit status bit 0 reports clean completion; register read-only
// - writing command bit 1 starts the device and clears reset flag
// - halt bit of remote command clears when remote dma completes
`timescale 1ns/10ps
`default_nettype none
module mirq_regs
  import mirq_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        rdma_done_evt,
  input  wire logic        tally_msb_any,
  input  wire logic        ring_full_evt,
  input  wire logic        tx_excess_coll_evt,
  input  wire logic        tx_underrun_evt,
  input  wire logic        rx_crc_err_evt,
  input  wire logic        rx_align_err_evt,
  input  wire logic        rx_overrun_evt,
  input  wire logic        rx_missed_evt,
  input  wire logic        rx_ok_evt,
  input  wire logic        tx_ok_evt,
  input  wire logic        tx_late_coll_evt,
  input  wire logic        tx_coll_evt,
  output logic             irq,
  output logic             cmd_start,
  output logic             cmd_stop,
  output logic             tx_request,
  output logic [2:0]       remote_cmd,
  output logic             word_xfer_sel,
  output logic             remote_xfer_force_done,
  output logic             full_duplex_sel,
  output logic             pad_inhibit,
  output logic [6:0]       pad_to_len,
  output logic             late_hit_retry,
  output logic [1:0]       loopback_sel,
  output logic             crc_inhibit
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  cmd;
    logic [7:0]  irq_status;
    logic [6:0]  irq_mask;
    logic [7:0]  data_config;
    logic [7:0]  tx_config;
    logic [7:0]  tx_status;
    logic        tally_q;
    logic        ph_v;
    logic        ph_w;
    logic        ph_map;
    logic [5:0]  ph_idx;
    logic [31:0] rdata;
  } mirq_state_t;

  mirq_state_t st_r;
  mirq_state_t st_nxt;

  // address decode shared by read and write paths
  function automatic logic mirq_mapped(input logic [31:0] a);
    logic [5:0] i;
    i = a[7:2];
    mirq_mapped = (a[31:8] == 24'h000000) && (a[1:0] == 2'h0) &&
                  (i == MIRQ_IDX_CMD || i == MIRQ_IDX_TSR ||
                   i == MIRQ_IDX_ISR || i == MIRQ_IDX_TCR ||
                   i == MIRQ_IDX_DCR || i == MIRQ_IDX_IMR);
  endfunction

  function automatic logic [31:0] mirq_read(input mirq_state_t s,
                                            input logic [5:0] i);
    mirq_read = 32'h00000000;
    // write-only configuration registers read back as zero
    if (i == MIRQ_IDX_CMD)
      mirq_read = {24'h000000, s.cmd};
    else if (i == MIRQ_IDX_ISR)
      mirq_read = {24'h000000, s.irq_status};
    else if (i == MIRQ_IDX_TSR)
      mirq_read = {24'h000000, s.tx_status};
  endfunction

  logic       addr_take;
  logic       wr_fire;
  logic       wr_cmd;
  logic [7:0] wbyte;
  logic       rdma_done;
  logic [6:0] isr_set;

  assign addr_take = clk_en & hsel & hready & htrans[1];
  assign wr_fire   = clk_en & st_r.ph_v & st_r.ph_w & st_r.ph_map;
  assign wbyte     = hwdata[7:0];
  assign wr_cmd    = wr_fire && (st_r.ph_idx == MIRQ_IDX_CMD);

  // forced completion fires on a new remote read or write command
  assign rdma_done = rdma_done_evt |
    (wr_cmd && st_r.data_config[MIRQ_DCR_FORCE] &&
     (wbyte[MIRQ_CMD_HALT:MIRQ_CMD_RD_LO] == MIRQ_RD_READ ||
      wbyte[MIRQ_CMD_HALT:MIRQ_CMD_RD_LO] == MIRQ_RD_WRITE));

  // ----------------------------------------------------------------
  // status event sources
  // ----------------------------------------------------------------
  always_comb
  begin
    isr_set = 7'h00;
    isr_set[MIRQ_ISR_RDC] = rdma_done;
    isr_set[MIRQ_ISR_CNT] = tally_msb_any & ~st_r.tally_q;
    isr_set[MIRQ_ISR_OVW] = ring_full_evt;
    isr_set[MIRQ_ISR_TXE] = tx_excess_coll_evt | tx_underrun_evt;
    isr_set[MIRQ_ISR_RXE] = rx_crc_err_evt | rx_align_err_evt |
                            rx_overrun_evt | rx_missed_evt;
    isr_set[MIRQ_ISR_PTX] = tx_ok_evt;
    isr_set[MIRQ_ISR_PRX] = rx_ok_evt;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.tally_q = tally_msb_any;
    if (wr_fire)
    begin
      unique case (st_r.ph_idx)
        MIRQ_IDX_CMD:
        begin
          st_nxt.cmd = wbyte;
          if (wbyte[MIRQ_CMD_TXP])
            st_nxt.tx_status = 8'h00;
        end
        MIRQ_IDX_ISR:
          // set beats the clear below; bit 7 ignores writes
          st_nxt.irq_status[6:0] = st_r.irq_status[6:0] & ~wbyte[6:0];
        MIRQ_IDX_IMR: st_nxt.irq_mask = wbyte[6:0];
        MIRQ_IDX_DCR: st_nxt.data_config = wbyte;
        MIRQ_IDX_TCR: st_nxt.tx_config = wbyte;
        default: st_nxt.ph_map = st_r.ph_map;
      endcase
    end
    // reset flag: stop enters reset state, start leaves it
    if (wr_cmd && wbyte[MIRQ_CMD_START])
      st_nxt.irq_status[MIRQ_ISR_RST] = 1'b0;
    else if (wr_cmd && wbyte[MIRQ_CMD_STOP])
      st_nxt.irq_status[MIRQ_ISR_RST] = 1'b1;
    st_nxt.irq_status[6:0] = st_nxt.irq_status[6:0] | isr_set;
    if (rdma_done)
      st_nxt.cmd[MIRQ_CMD_HALT] = 1'b0;
    // transmit request drops once the frame is finished either way
    if (tx_ok_evt | tx_excess_coll_evt)
      st_nxt.cmd[MIRQ_CMD_TXP] = 1'b0;
    if (tx_late_coll_evt)
      st_nxt.tx_status[MIRQ_TSR_OWC] = 1'b1;
    if (tx_excess_coll_evt)
      st_nxt.tx_status[MIRQ_TSR_ABT] = 1'b1;
    if (tx_coll_evt)
      st_nxt.tx_status[MIRQ_TSR_COL] = 1'b1;
    if (tx_ok_evt)
      st_nxt.tx_status[MIRQ_TSR_PTX] = 1'b1;
    // bus phase capture; no wait states while clk_en is high, so every phase is one enabled cycle
    st_nxt.ph_v = addr_take;
    st_nxt.ph_w = hwrite;
    st_nxt.ph_map = mirq_mapped(haddr);
    st_nxt.ph_idx = haddr[7:2];
    // read data from the next state, so a write just ahead is seen
    if (addr_take && !hwrite && mirq_mapped(haddr))
      st_nxt.rdata = mirq_read(st_nxt, haddr[7:2]);
    else if (addr_take)
      st_nxt.rdata = 32'h00000000;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r <= '{cmd: MIRQ_CMD_RST, irq_status: MIRQ_ISR_RSTV, irq_mask: 7'h00,
                data_config: 8'h00, tx_config: 8'h00, tx_status: 8'h00, tally_q: 1'b0,
                ph_v: 1'b0, ph_w: 1'b0, ph_map: 1'b0, ph_idx: 6'h00,
                rdata: 32'h00000000};
    end
    else if (clk_en)
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // a frozen clock stretches the data phase instead of losing it
  assign hreadyout = clk_en;
  assign hresp     = 1'b0;
  assign hrdata    = st_r.rdata;
  assign irq       = |(st_r.irq_status[6:0] & st_r.irq_mask);
  assign cmd_start  = st_r.cmd[MIRQ_CMD_START];
  assign cmd_stop   = st_r.cmd[MIRQ_CMD_STOP];
  assign tx_request = st_r.cmd[MIRQ_CMD_TXP];
  assign remote_cmd = st_r.cmd[MIRQ_CMD_HALT:MIRQ_CMD_RD_LO];
  assign word_xfer_sel          = st_r.data_config[MIRQ_DCR_WORD];
  assign remote_xfer_force_done = st_r.data_config[MIRQ_DCR_FORCE];
  assign full_duplex_sel = st_r.tx_config[MIRQ_TCR_FDX];
  assign pad_inhibit     = st_r.tx_config[MIRQ_TCR_PAD];
  assign pad_to_len      = st_r.tx_config[MIRQ_TCR_PAD] ? 7'h00 : MIRQ_PAD_BYTES;
  assign late_hit_retry  = st_r.tx_config[MIRQ_TCR_RETRY];
  assign loopback_sel    = st_r.tx_config[MIRQ_TCR_LB_LO+1:MIRQ_TCR_LB_LO];
  assign crc_inhibit     = st_r.tx_config[MIRQ_TCR_CRC];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking mirq_cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_rst_on_stop: assert property (wr_cmd && wbyte[0] && !wbyte[1]
    |=> st_r.irq_status[7]) else $error("reset flag not set by stop");
  a_rst_on_start: assert property (wr_cmd && wbyte[1]
    |=> !st_r.irq_status[7]) else $error("reset flag not cleared by start");
  a_rdc_set: assert property (clk_en && rdma_done_evt
    |=> st_r.irq_status[6] && !st_r.cmd[5]) else $error("remote done lost");
  a_cnt_rise: assert property (clk_en && tally_msb_any && !st_r.tally_q
    |=> st_r.irq_status[5]) else $error("tally overflow lost");
  a_ovw_set: assert property (clk_en && ring_full_evt
    |=> st_r.irq_status[4]) else $error("ring full lost");
  a_txe_set: assert property (clk_en && (tx_excess_coll_evt || tx_underrun_evt)
    |=> st_r.irq_status[3] && (st_r.tx_status[3] || !$past(tx_excess_coll_evt)))
    else $error("tx fault lost");
  a_rxe_set: assert property (clk_en && (rx_crc_err_evt || rx_missed_evt)
    |=> st_r.irq_status[2]) else $error("rx fault lost");
  a_ptx_set: assert property (clk_en && tx_ok_evt
    |=> st_r.irq_status[1] && st_r.tx_status[0]) else $error("tx done lost");
  a_prx_set: assert property (clk_en && rx_ok_evt
    |=> st_r.irq_status[0]) else $error("rx done lost");
  a_irq_gate: assert property (clk_en && wr_fire && st_r.ph_idx == 6'h0f
    && hwdata[6:0] == 7'h00 |=> !irq) else $error("irq not masked");
  a_force_done: assert property (wr_cmd && st_r.data_config[7] && wbyte[5:3] == 3'h1
    |=> st_r.irq_status[6]) else $error("forced completion missing");
  a_tcr_load: assert property (wr_fire && st_r.ph_idx == 6'h0d
    |=> full_duplex_sel == $past(hwdata[7]) &&
        loopback_sel == $past(hwdata[2:1]) &&
        crc_inhibit == $past(hwdata[0])) else $error("tx config not loaded");
  a_owc_set: assert property (clk_en && tx_late_coll_evt
    |=> st_r.tx_status[7]) else $error("late collision lost");
  a_col_set: assert property (clk_en && tx_coll_evt
    |=> st_r.tx_status[2]) else $error("collision lost");
  a_irq_level: assert property (clk_en && st_r.irq_status[1] && st_r.irq_mask[1]
    && !(wr_fire && st_r.ph_idx == 6'h07 && hwdata[1])
    && !(wr_fire && st_r.ph_idx == 6'h0f && !hwdata[1]) |=> irq)
    else $error("irq not raised");

  // ----------------------------------------------------------------
  // status flag checks
  // ----------------------------------------------------------------
  // a status write may only touch bits 6..0, never the reset flag
  a_rst_no_write: assert property (wr_fire && st_r.ph_idx == 6'h07
    |=> st_r.irq_status[7] == $past(st_r.irq_status[7]))
    else $error("reset flag changed by a status write");
  a_cnt_track: assert property (clk_en
    |=> st_r.tally_q == $past(tally_msb_any))
    else $error("tally edge detector lost step");
  a_txe_under: assert property (clk_en && tx_underrun_evt
    |=> st_r.irq_status[3])
    else $error("underrun not flagged");
  a_rxe_other: assert property (clk_en && (rx_align_err_evt || rx_overrun_evt)
    |=> st_r.irq_status[2])
    else $error("alignment or overrun not flagged");
  a_isr_w1c: assert property (wr_fire && st_r.ph_idx == 6'h07 && hwdata[0]
    && !rx_ok_evt |=> !st_r.irq_status[0])
    else $error("write one did not clear status");
  // a set in the same cycle as its clear must survive
  a_set_wins: assert property (wr_fire && st_r.ph_idx == 6'h07 && tx_ok_evt
    |=> st_r.irq_status[1])
    else $error("set lost against clear");

  // ----------------------------------------------------------------
  // command and remote completion checks
  // ----------------------------------------------------------------
  a_force_write: assert property (wr_cmd && st_r.data_config[7] && wbyte[5:3] == 3'h2
    |=> st_r.irq_status[6])
    else $error("forced write completion missing");
  a_no_force: assert property (wr_cmd && !st_r.data_config[7] && !rdma_done_evt
    |=> st_r.cmd[5] == $past(wbyte[5]))
    else $error("halt bit changed without completion");
  a_halt_clear: assert property (clk_en && rdma_done
    |=> !st_r.cmd[5])
    else $error("halt bit kept after completion");
  a_start_out: assert property (wr_cmd && wbyte[1]
    |=> cmd_start)
    else $error("start output not raised");
  // the request would otherwise resend a frame already finished
  a_txreq_drop: assert property (clk_en && (tx_ok_evt || tx_excess_coll_evt)
    |=> !tx_request)
    else $error("tx request kept after frame end");

  // ----------------------------------------------------------------
  // transmit status checks
  // ----------------------------------------------------------------
  a_abt_set: assert property (clk_en && tx_excess_coll_evt
    |=> st_r.tx_status[3])
    else $error("abort not flagged");
  a_tsr_ro: assert property (wr_fire && st_r.ph_idx == 6'h04 && !tx_late_coll_evt
    && !tx_excess_coll_evt && !tx_coll_evt && !tx_ok_evt
    |=> st_r.tx_status == $past(st_r.tx_status)) else $error("tx status was written");

  // ----------------------------------------------------------------
  // configuration and mask checks
  // ----------------------------------------------------------------
  a_imr_load: assert property (wr_fire && st_r.ph_idx == 6'h0f
    |=> st_r.irq_mask == $past(hwdata[6:0]))
    else $error("mask not loaded");
  a_dcr_load: assert property (wr_fire && st_r.ph_idx == 6'h0e
    |=> word_xfer_sel == $past(hwdata[0]) && remote_xfer_force_done == $past(hwdata[7]))
    else $error("data config not loaded");
  a_pad_load: assert property (wr_fire && st_r.ph_idx == 6'h0d
    |=> pad_inhibit == $past(hwdata[6]) && late_hit_retry == $past(hwdata[5]))
    else $error("pad or retry not loaded");
  a_pad_len: assert property (!pad_inhibit
    |-> pad_to_len == MIRQ_PAD_BYTES)
    else $error("pad length wrong");
  // the write-only mask register must never leak its contents
  a_wo_read: assert property (addr_take && !hwrite && haddr[7:2] == 6'h0f
    |=> hrdata == 32'h00000000)
    else $error("mask readable");
  a_irq_quiet: assert property ((st_r.irq_status[6:0] & st_r.irq_mask) == 7'h00
    |-> !irq)
    else $error("irq without enabled source");

endmodule
`default_nettype wire

// ### core/mirq_pkg.sv
/*
  mirq_pkg: register indices, field positions, reset values and codes
  for the mac interrupt / transmit configuration register group.
  assumes a 32-bit ahb-lite bus, one word per register index.
*/
package mirq_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [5:0] MIRQ_IDX_CMD  = 6'h00;
  localparam logic [5:0] MIRQ_IDX_TSR  = 6'h04;
  localparam logic [5:0] MIRQ_IDX_ISR  = 6'h07;
  localparam logic [5:0] MIRQ_IDX_TCR  = 6'h0d;
  localparam logic [5:0] MIRQ_IDX_DCR  = 6'h0e;
  localparam logic [5:0] MIRQ_IDX_IMR  = 6'h0f;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MIRQ_CMD_STOP  = 0;
  localparam int MIRQ_CMD_START = 1;
  localparam int MIRQ_CMD_TXP   = 2;
  localparam int MIRQ_CMD_RD_LO = 3;
  localparam int MIRQ_CMD_HALT  = 5;
  localparam int MIRQ_ISR_RST   = 7;
  localparam int MIRQ_ISR_RDC   = 6;
  localparam int MIRQ_ISR_CNT   = 5;
  localparam int MIRQ_ISR_OVW   = 4;
  localparam int MIRQ_ISR_TXE   = 3;
  localparam int MIRQ_ISR_RXE   = 2;
  localparam int MIRQ_ISR_PTX   = 1;
  localparam int MIRQ_ISR_PRX   = 0;
  localparam int MIRQ_DCR_FORCE = 7;
  localparam int MIRQ_DCR_WORD  = 0;
  localparam int MIRQ_TCR_FDX   = 7;
  localparam int MIRQ_TCR_PAD   = 6;
  localparam int MIRQ_TCR_RETRY = 5;
  localparam int MIRQ_TCR_LB_LO = 1;
  localparam int MIRQ_TCR_CRC   = 0;
  localparam int MIRQ_TSR_OWC   = 7;
  localparam int MIRQ_TSR_ABT   = 3;
  localparam int MIRQ_TSR_COL   = 2;
  localparam int MIRQ_TSR_PTX   = 0;
  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] MIRQ_CMD_RST    = 8'h21;
  localparam logic [7:0] MIRQ_ISR_RSTV   = 8'h80;
  localparam logic [2:0] MIRQ_RD_READ    = 3'h1;
  localparam logic [2:0] MIRQ_RD_WRITE   = 3'h2;
  localparam logic [1:0] MIRQ_LB_NORMAL  = 2'h0;
  localparam logic [1:0] MIRQ_LB_INTERN  = 2'h1;
  localparam logic [1:0] MIRQ_LB_PHY     = 2'h2;
  localparam logic [6:0] MIRQ_PAD_BYTES  = 7'h3c;
  localparam logic [1:0] MIRQ_HTRANS_NSQ = 2'h2;
endpackage

// ### verification/mirq_host.sv
/*
  mirq_host: behavioural ahb-lite master standing in for host software.
  assumes one slave whose hreadyout is fed back as hready.
*/
`timescale 1ns/10ps
`default_nettype none
module mirq_host
  import mirq_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  // ----------------------------------------------------------------
  // single word transfer, address phase then data phase
  // ----------------------------------------------------------------
  initial
  begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= MIRQ_HTRANS_NSQ;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    // released address must not look like the last one
    hsel   <= 1'b0;
    haddr  <= ~a;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    hwdata <= ~wd;
  endtask
endmodule
`default_nettype wire

// ### verification/tb_top.sv
/*
  tb_top: self-checking bench for mirq_regs with a bitwise status model.
  assumes the host model drives the bus and the bench pulses events.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b, m) if ((a) !== (b)) note_bad(m); else n_tests++;
module tb_top
  import mirq_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        hclk = 1'b0;
  logic        hresetn, clk_en, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, loopback_sel;
  logic [2:0]  hsize, remote_cmd;
  logic [6:0]  pad_to_len;
  logic [12:0] ev;
  logic        wsel, fdone, fdx, padi, lretry, crci, txreq, cst, csp;
  logic [7:0]  isr_m, tsr_m, r, v;
  int          fail_count = 0;
  int          n_tests = 0;
  int          isr_of[13] = '{6, 5, 4, 3, 3, 2, 2, 2, 2, 0, 1, -1, -1};
  int          tsr_of[13] = '{-1, -1, -1, 3, -1, -1, -1, -1, -1, -1, 0, 7, 2};

  always #5 hclk = ~hclk;

  mirq_host host_inst (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  mirq_regs mirq_regs_inst (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .rdma_done_evt(ev[0]), .tally_msb_any(ev[1]), .ring_full_evt(ev[2]),
    .tx_excess_coll_evt(ev[3]), .tx_underrun_evt(ev[4]), .rx_crc_err_evt(ev[5]),
    .rx_align_err_evt(ev[6]), .rx_overrun_evt(ev[7]), .rx_missed_evt(ev[8]),
    .rx_ok_evt(ev[9]), .tx_ok_evt(ev[10]), .tx_late_coll_evt(ev[11]),
    .tx_coll_evt(ev[12]), .irq(irq), .cmd_start(cst), .cmd_stop(csp), .tx_request(txreq),
    .remote_cmd(remote_cmd), .word_xfer_sel(wsel), .remote_xfer_force_done(fdone),
    .full_duplex_sel(fdx), .pad_inhibit(padi), .pad_to_len(pad_to_len),
    .late_hit_retry(lretry), .loopback_sel(loopback_sel), .crc_inhibit(crci));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic note_bad(input string m);
    fail_count++;
    n_tests++;
    $display("mismatch t=%0t %s", $time, m);
  endtask

  task automatic give_verdict;
    if (fail_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic logic [31:0] ad(input logic [5:0] idx);
    return {24'h0, idx, 2'b00};
  endfunction

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] dummy;
    host_inst.xfer(ad(idx), 1'b1, {24'h0, d}, dummy);
  endtask

  task automatic rdchk(input logic [5:0] idx, input logic [7:0] e, input string m);
    logic [31:0] d;
    host_inst.xfer(ad(idx), 1'b0, 32'h0, d);
    `CHK(d, {24'h0, e}, m)
    `CHK(hresp, 1'b0, "response not okay")
  endtask

  // one enabled cycle per event, then look at the settled outputs
  task automatic pulse(input int i);
    @(posedge hclk);
    ev[i] <= 1'b1;
    @(posedge hclk);
    ev[i] <= 1'b0;
    @(negedge hclk);
  endtask

  // ----------------------------------------------------------------
  // watchdog: whole sequence needs well under a thousand cycles
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5000) @(posedge hclk);
    fail_count++;
    give_verdict;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    hresetn = 1'b0;
    clk_en  = 1'b1;
    ev      = 13'h0;
    isr_m   = MIRQ_ISR_RSTV;
    tsr_m   = 8'h00;
    void'($urandom(32'he85f7149));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(MIRQ_IDX_CMD, 8'h21, "cmd reset");
    rdchk(MIRQ_IDX_ISR, isr_m, "status reset");
    rdchk(MIRQ_IDX_TSR, 8'h00, "tx status reset");
    rdchk(MIRQ_IDX_IMR, 8'h00, "mask reads zero");
    rdchk(MIRQ_IDX_TCR, 8'h00, "tx config reads zero");
    rdchk(MIRQ_IDX_DCR, 8'h00, "data config reads zero");
    `CHK(irq, 1'b0, "irq after reset")
    `CHK(remote_cmd, 3'h4, "remote halt at reset")
    `CHK({cst, csp}, 2'b01, "start and stop at reset")
    pulse(0);
    isr_m[6] = 1'b1;
    `CHK(remote_cmd[2], 1'b0, "halt not cleared on done")
    wr(MIRQ_IDX_CMD, 8'h02);
    isr_m[7] = 1'b0;
    rdchk(MIRQ_IDX_ISR, isr_m, "start vs reset flag");
    wr(MIRQ_IDX_ISR, 8'hff);
    isr_m = 8'h00;
    rdchk(MIRQ_IDX_ISR, isr_m, "flag write or clear");
    // forced completion: a remote read code finishes at once
    wr(MIRQ_IDX_DCR, 8'h81);
    @(negedge hclk);
    `CHK({fdone, wsel}, 2'b11, "data config fields")
    wr(MIRQ_IDX_CMD, 8'h0a);
    isr_m[6] = 1'b1;
    rdchk(MIRQ_IDX_ISR, isr_m, "forced remote done");
    wr(MIRQ_IDX_ISR, isr_m);
    isr_m = 8'h00;
    wr(MIRQ_IDX_CMD, 8'h01);
    rdchk(MIRQ_IDX_ISR, 8'h80, "stop sets reset flag");
    `CHK({cst, csp}, 2'b01, "stop output")
    wr(MIRQ_IDX_CMD, 8'h06);
    tsr_m = 8'h00;
    @(negedge hclk);
    `CHK({cst, txreq}, 2'b11, "start and tx request")
    for (int i = 0; i < 13; i++)
    begin
      r = $urandom;
      wr(MIRQ_IDX_IMR, r);
      pulse(i);
      if (isr_of[i] >= 0) isr_m[isr_of[i]] = 1'b1;
      if (tsr_of[i] >= 0) tsr_m[tsr_of[i]] = 1'b1;
      `CHK(irq, |(isr_m[6:0] & r[6:0]), "irq vs masked status")
      rdchk(MIRQ_IDX_ISR, isr_m, "event status");
      rdchk(MIRQ_IDX_TSR, tsr_m, "tx status");
      wr(MIRQ_IDX_ISR, isr_m);
      isr_m = 8'h00;
      @(negedge hclk);
      `CHK(irq, 1'b0, "irq after clear")
    end
    wr(MIRQ_IDX_TSR, 8'h00);
    rdchk(MIRQ_IDX_TSR, tsr_m, "tx status written");
    `CHK(txreq, 1'b0, "tx request idle")
    for (int i = 0; i < 3; i++)
    begin
      v = $urandom;
      v[2:1] = i[1:0];
      wr(MIRQ_IDX_TCR, v);
      @(negedge hclk);
      `CHK(fdx, v[7], "duplex")
      `CHK(padi, v[6], "pad inhibit")
      `CHK(pad_to_len, (v[6] ? 7'h00 : MIRQ_PAD_BYTES), "pad length")
      `CHK(lretry, v[5], "late retry")
      `CHK(loopback_sel, v[2:1], "loopback")
      `CHK(crci, v[0], "crc inhibit")
    end
    wr(6'h01, 8'hff);
    rdchk(6'h01, 8'h00, "unmapped read");
    // frozen clock enable: event must not land
    @(posedge hclk);
    clk_en <= 1'b0;
    ev[2]  <= 1'b1;
    @(negedge hclk);
    `CHK(hreadyout, 1'b0, "ready while frozen")
    @(posedge hclk);
    clk_en <= 1'b1;
    ev[2]  <= 1'b0;
    rdchk(MIRQ_IDX_ISR, isr_m, "event while frozen");
    give_verdict;
  end
endmodule
`default_nettype wire
